// ### common/pulse_gen_pkg.sv
// Shared constants for the dual pulse train / modulation generator.
// Assumes a 40 MHz clock and an AXI4-Lite register master.
package pulse_gen_pkg;

  // ----------------------------------------------------------------
  // Clock and tick bases
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;   // System clock rate
  localparam int unsigned TICK_US_NS    = 1_000;        // Short tick, ns
  localparam int unsigned TICK_MS_NS    = 1_000_000;    // Long tick, ns
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned US_CYCLES     = TICK_US_NS / CLK_PERIOD_NS;  // 40
  localparam int unsigned MS_CYCLES     = TICK_MS_NS / CLK_PERIOD_NS;  // 40000

  // ----------------------------------------------------------------
  // Register byte offsets, per channel block of 0x20
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_STRIDE   = 8'h20;  // Channel one base
  localparam logic [7:0] OFS_CTRL    = 8'h00;  // Control byte
  localparam logic [7:0] OFS_CYCLE   = 8'h04;  // Cycle time
  localparam logic [7:0] OFS_WIDTH   = 8'h08;  // Pulse width
  localparam logic [7:0] OFS_COUNT   = 8'h0c;  // Pulse count
  localparam logic [7:0] OFS_STATUS  = 8'h10;  // Idle / overflow
  localparam logic [7:0] OFS_INVOKE  = 8'h40;  // Pulse invoke op
  localparam logic [7:0] OFS_RUN     = 8'h44;  // Run mode entry

  // ----------------------------------------------------------------
  // Control byte fields
  // ----------------------------------------------------------------
  localparam int CTL_UPD_CYCLE = 0;  // Load cycle time
  localparam int CTL_UPD_WIDTH = 1;  // Load pulse width
  localparam int CTL_UPD_COUNT = 2;  // Load pulse count
  localparam int CTL_BASE_MS   = 3;  // 1 = millisecond tick
  localparam int CTL_MODE_PWM  = 6;  // 1 = modulation mode
  localparam int CTL_ENABLE    = 7;  // Generator enable

  // Status fields
  localparam int STS_OVERFLOW  = 6;  // Pipeline overflow, sticky
  localparam int STS_IDLE      = 7;  // Train idle

  // Reset values and limits
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] MIN_CYCLE   = 16'h0002;
  localparam logic [1:0]  AXI_OKAY    = 2'b00;
  localparam logic [1:0]  AXI_SLVERR  = 2'b10;

endpackage : pulse_gen_pkg

// ### verilog/pulse_gen_channel.sv
// One pulse generator: applied settings, two-deep train pipeline, output.
// Assumes invoke is a one-cycle pulse with staged values held steady.
`timescale 1ns/1ps
module pulse_gen_channel
  import pulse_gen_pkg::*;
#(
  parameter int unsigned US_DIV = US_CYCLES,  // Clocks per short tick
  parameter int unsigned MS_DIV = MS_CYCLES   // Clocks per long tick
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        invoke,       // Pulse invoke for this channel
  input  wire logic        run_entry,    // Entry into run mode
  input  wire logic        ovf_clear,    // Software clear of overflow
  input  wire logic [7:0]  stage_ctrl,   // Staged control byte
  input  wire logic [15:0] stage_cycle,  // Staged cycle time
  input  wire logic [15:0] stage_width,  // Staged pulse width
  input  wire logic [31:0] stage_count,  // Staged pulse count
  output logic             pulse_out,    // Discrete output
  output logic             idle,         // Train idle flag
  output logic             overflow      // Pipeline overflow flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        en, pwm, base_ms;            // Applied mode bits
  logic [15:0] cyc, wid;                    // Applied cycle, width
  logic [31:0] cnt;                         // Applied pulse count
  logic        busy;                        // Train running
  logic        pend;                        // Second spec waiting
  logic        p_ms;                        // Pending spec base
  logic [15:0] p_cyc;                       // Pending cycle
  logic [31:0] p_cnt;                       // Pending count
  logic [15:0] tick_pos;                    // Ticks into current cycle
  logic [31:0] left;                        // Pulses still to emit
  logic [15:0] pre;                         // Clock prescaler
  logic        next_en, next_pwm, next_base_ms, next_busy, next_pend, next_p_ms;
  logic [15:0] next_cyc, next_wid, next_p_cyc, next_tick_pos, next_pre;
  logic [31:0] next_cnt, next_p_cnt, next_left;
  logic        next_out, next_ovf;

  // Effective cycle with the two-tick floor
  function automatic logic [15:0] eff_cycle(input logic [15:0] c);
    return (c < MIN_CYCLE) ? MIN_CYCLE : c;
  endfunction : eff_cycle

  // Tick length in clocks for the chosen base
  function automatic logic [15:0] tick_len(input logic ms);
    return ms ? 16'(MS_DIV) : 16'(US_DIV);
  endfunction : tick_len

  logic [15:0] c_eff;   // Floored applied cycle
  logic        tick;    // One-cycle tick strobe
  logic        cyc_end; // Last tick of a cycle
  assign c_eff   = eff_cycle(cyc);
  assign tick    = (pre == tick_len(base_ms) - 16'h0001);
  assign cyc_end = tick && (tick_pos == c_eff - 16'h0001);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_en = en; next_pwm = pwm; next_base_ms = base_ms;
    next_cyc = cyc; next_wid = wid; next_cnt = cnt;
    next_busy = busy; next_pend = pend; next_p_ms = p_ms;
    next_p_cyc = p_cyc; next_p_cnt = p_cnt;
    next_left = left; next_tick_pos = tick_pos;
    next_pre = tick ? 16'h0000 : pre + 16'h0001;
    next_ovf = overflow;
    // Cycle position advance
    if (tick) begin
      next_tick_pos = cyc_end ? 16'h0000 : tick_pos + 16'h0001;
    end
    // Train progress
    if (busy && cyc_end) begin
      if (left == 32'h0000_0001) begin
        if (pend) begin
          next_cyc = p_cyc; next_cnt = p_cnt; next_base_ms = p_ms;
          next_left = p_cnt; next_pend = 1'b0;
        end else begin
          next_busy = 1'b0;
        end
      end else begin
        next_left = left - 32'h0000_0001;
      end
    end
    if (run_entry || ovf_clear) begin
      next_ovf = 1'b0;
    end
    if (invoke) begin
      next_en      = stage_ctrl[CTL_ENABLE];
      next_pwm     = stage_ctrl[CTL_MODE_PWM];
      if (stage_ctrl[CTL_ENABLE] && !stage_ctrl[CTL_MODE_PWM] && busy) begin
        if (pend) begin
          next_ovf = 1'b1;
        end else begin
          next_pend  = 1'b1;
          next_p_ms  = stage_ctrl[CTL_BASE_MS];
          next_p_cyc = stage_ctrl[CTL_UPD_CYCLE] ? stage_cycle : cyc;
          next_p_cnt = stage_ctrl[CTL_UPD_COUNT] ? stage_count : cnt;
        end
      end else begin
        next_base_ms = stage_ctrl[CTL_BASE_MS];
        if (stage_ctrl[CTL_UPD_CYCLE]) next_cyc = stage_cycle;
        if (stage_ctrl[CTL_UPD_WIDTH]) next_wid = stage_width;
        if (stage_ctrl[CTL_UPD_COUNT]) next_cnt = stage_count;
        next_pre = 16'h0000; next_tick_pos = 16'h0000;
        next_pend = 1'b0;
        next_left = stage_ctrl[CTL_UPD_COUNT] ? stage_count : cnt;
        next_busy = stage_ctrl[CTL_ENABLE] && !stage_ctrl[CTL_MODE_PWM] && (next_left != 32'h0);
      end
    end
    // Output level
    if (!en) begin
      next_out = 1'b0;
    end else if (pwm) begin
      // high for width ticks; full, zero
      next_out = (next_tick_pos < next_wid);
    end else begin
      // half-period square wave; odd high half rounds down
      next_out = next_busy && (next_tick_pos < (eff_cycle(next_cyc) >> 1));
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= 1'b0; pwm <= 1'b0; base_ms <= 1'b0;
      cyc <= 16'h0000; wid <= 16'h0000; cnt <= 32'h0000_0000;
      busy <= 1'b0; pend <= 1'b0; p_ms <= 1'b0;
      p_cyc <= 16'h0000; p_cnt <= 32'h0000_0000;
      left <= 32'h0000_0000; tick_pos <= 16'h0000; pre <= 16'h0000;
      pulse_out <= 1'b0; overflow <= 1'b0;
    end else begin
      en <= next_en; pwm <= next_pwm; base_ms <= next_base_ms;
      cyc <= next_cyc; wid <= next_wid; cnt <= next_cnt;
      busy <= next_busy; pend <= next_pend; p_ms <= next_p_ms;
      p_cyc <= next_p_cyc; p_cnt <= next_p_cnt;
      left <= next_left; tick_pos <= next_tick_pos; pre <= next_pre;
      pulse_out <= next_out; overflow <= next_ovf;
    end
  end

  // idle reads one when no train
  assign idle = !busy;

endmodule : pulse_gen_channel

// ### verilog/pulse_gen_top.sv
// Dual pulse train / modulation generator with AXI4-Lite register access.
// Assumes one AXI4-Lite master; outputs go to external loads.
//
// Behaviour
// - train is square wave, counted, stops
// - pulse count one to 32-bit max
// - one tick base, microsecond or millisecond
// - cycle below two becomes two
// - odd cycle may skew duty
// - modulation high for width each cycle
// - width equal cycle stays high
// - width zero stays low
// - width update restarts, not cycle-aligned
// - control byte, 16/16/32-bit values
// - staged values apply only on invoke
// - idle and overflow status per generator
// - second train chains with no gap unless invoked in the clock the first ends, then dropped
// - third spec while busy sets overflow
// - overflow cleared at run or by status write, else sticky
// - control byte bit assignments
// - idle zero while a train runs, one otherwise
// - all values zero after reset
`timescale 1ns/1ps
module pulse_gen_top
  import pulse_gen_pkg::*;
#(
  parameter int unsigned MS_DIV = pulse_gen_pkg::MS_CYCLES  // Clocks per ms tick
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic             pulse_output_zero,
  output logic             pulse_output_one
);

  // ----------------------------------------------------------------
  // Staged register storage, indexed by channel
  // ----------------------------------------------------------------
  // staged values
  logic [7:0]  ctrl  [2];       // Staged control bytes
  logic [15:0] cycle [2];       // Staged cycle times
  logic [15:0] width [2];       // Staged pulse widths
  logic [31:0] count [2];       // Staged pulse counts
  logic [7:0]  next_ctrl  [2];
  logic [15:0] next_cycle [2];
  logic [15:0] next_width [2];
  logic [31:0] next_count [2];
  logic [1:0]  invoke;          // Per-channel invoke strobes
  logic [1:0]  ovf_clear;       // Per-channel overflow clears
  logic        run_entry;       // Run mode entry strobe
  logic [1:0]  idle, ovf, outs; // Channel status and outputs

  // ----------------------------------------------------------------
  // Write channel state
  // ----------------------------------------------------------------
  logic       aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic       next_bvalid;
  logic [1:0] next_bresp;
  logic       do_write;         // Both halves present

  // Byte-lane merge of one word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Is the address mapped
  function automatic logic mapped(input logic [7:0] a);
    logic [7:0] o;
    o = (a >= CH_STRIDE && a < OFS_INVOKE) ? a - CH_STRIDE : a;
    return (a == OFS_INVOKE) || (a == OFS_RUN) ||
           (a < OFS_INVOKE && o <= OFS_STATUS && o[1:0] == 2'b00);
  endfunction : mapped

  assign s_axil_awready = !aw_held && !s_axil_bvalid;
  assign s_axil_wready  = !w_held && !s_axil_bvalid;
  assign do_write       = aw_held && w_held && !s_axil_bvalid;

  // Capture halves, decode write, raise response
  always_comb begin
    logic       ch;
    logic [7:0] o;
    ch = aw_addr >= CH_STRIDE;
    o  = ch ? aw_addr - CH_STRIDE : aw_addr;
    next_aw_held = aw_held; next_w_held = w_held;
    next_aw_addr = aw_addr; next_w_data = w_data; next_w_strb = w_strb;
    next_bvalid = s_axil_bvalid; next_bresp = s_axil_bresp;
    for (int c = 0; c < 2; c++) begin
      next_ctrl[c] = ctrl[c]; next_cycle[c] = cycle[c];
      next_width[c] = width[c]; next_count[c] = count[c];
    end
    invoke = 2'b00; ovf_clear = 2'b00; run_entry = 1'b0;
    if (s_axil_awvalid && s_axil_awready) begin
      next_aw_held = 1'b1; next_aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      next_w_held = 1'b1; next_w_data = s_axil_wdata; next_w_strb = s_axil_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0; next_w_held = 1'b0; next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? AXI_OKAY : AXI_SLVERR;
      if (aw_addr == OFS_INVOKE) begin
        if (w_strb[0]) invoke[w_data[0]] = 1'b1;
      end else if (aw_addr == OFS_RUN) begin
        run_entry = w_strb[0] & w_data[0];
      end else if (aw_addr < OFS_INVOKE) begin
        case (o)
          OFS_CTRL:   next_ctrl[ch]  = 8'(merge({24'h0, ctrl[ch]}, w_data, w_strb));
          OFS_CYCLE:  next_cycle[ch] = 16'(merge({16'h0, cycle[ch]}, w_data, w_strb));
          OFS_WIDTH:  next_width[ch] = 16'(merge({16'h0, width[ch]}, w_data, w_strb));
          OFS_COUNT:  next_count[ch] = merge(count[ch], w_data, w_strb);
          OFS_STATUS: ovf_clear[ch]  = w_strb[0] & w_data[STS_OVERFLOW];
          default:    next_bresp = AXI_SLVERR;
        endcase
      end
    end
    if (s_axil_bvalid && s_axil_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write-side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0; w_held <= 1'b0; aw_addr <= 8'h00;
      w_data <= 32'h0000_0000; w_strb <= 4'h0;
      s_axil_bvalid <= 1'b0; s_axil_bresp <= AXI_OKAY;
      for (int c = 0; c < 2; c++) begin
        ctrl[c] <= CTRL_RESET; cycle[c] <= 16'h0000;
        width[c] <= 16'h0000; count[c] <= 32'h0000_0000;
      end
    end else begin
      aw_held <= next_aw_held; w_held <= next_w_held; aw_addr <= next_aw_addr;
      w_data <= next_w_data; w_strb <= next_w_strb;
      s_axil_bvalid <= next_bvalid; s_axil_bresp <= next_bresp;
      for (int c = 0; c < 2; c++) begin
        ctrl[c] <= next_ctrl[c]; cycle[c] <= next_cycle[c];
        width[c] <= next_width[c]; count[c] <= next_count[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  assign s_axil_arready = !s_axil_rvalid;

  // Decode read address into data
  always_comb begin
    logic       ch;
    logic [7:0] o;
    ch = s_axil_araddr >= CH_STRIDE;
    o  = ch ? s_axil_araddr - CH_STRIDE : s_axil_araddr;
    next_rvalid = s_axil_rvalid; next_rdata = s_axil_rdata; next_rresp = s_axil_rresp;
    if (s_axil_arvalid && s_axil_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = AXI_OKAY;
      next_rdata  = 32'h0000_0000;
      if (s_axil_araddr == OFS_INVOKE || s_axil_araddr == OFS_RUN) begin
        next_rdata = 32'h0000_0000;   // Write-only strobes
      end else if (!mapped(s_axil_araddr)) begin
        next_rresp = AXI_SLVERR;
      end else begin
        case (o)
          OFS_CTRL:   next_rdata = {24'h0, ctrl[ch]};
          OFS_CYCLE:  next_rdata = {16'h0, cycle[ch]};
          OFS_WIDTH:  next_rdata = {16'h0, width[ch]};
          OFS_COUNT:  next_rdata = count[ch];
          OFS_STATUS: next_rdata = {24'h0, idle[ch], ovf[ch], 6'h00};
          default:    next_rresp = AXI_SLVERR;
        endcase
      end
    end else if (s_axil_rvalid && s_axil_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Read-side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0; s_axil_rdata <= 32'h0000_0000; s_axil_rresp <= AXI_OKAY;
    end else begin
      s_axil_rvalid <= next_rvalid; s_axil_rdata <= next_rdata; s_axil_rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Generators
  // ----------------------------------------------------------------
  // two independent generators
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    pulse_gen_channel #(
      .US_DIV (US_CYCLES),
      .MS_DIV (MS_DIV)
    ) u_ch (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .invoke      (invoke[g]),
      .run_entry   (run_entry),
      .ovf_clear   (ovf_clear[g]),
      .stage_ctrl  (ctrl[g]),
      .stage_cycle (cycle[g]),
      .stage_width (width[g]),
      .stage_count (count[g]),
      .pulse_out   (outs[g]),
      .idle        (idle[g]),
      .overflow    (ovf[g])
    );
  end

  assign pulse_output_zero = outs[0];
  assign pulse_output_one  = outs[1];

endmodule : pulse_gen_top

// ### tb/pulse_gen_top_assertions.sv
// Concurrent checks on the pulse generator top ports.
// Assumes binding into pulse_gen_top, one clock, sync reset.
`timescale 1ns/1ps
module pulse_gen_top_checker
  import pulse_gen_pkg::*;
#(
  parameter int unsigned MS_DIV = 4  // Clocks per ms tick
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axil_awvalid,
  input wire logic       s_axil_awready,
  input wire logic       s_axil_wvalid,
  input wire logic       s_axil_wready,
  input wire logic       s_axil_bvalid,
  input wire logic [7:0] s_axil_araddr,
  input wire logic       s_axil_arvalid,
  input wire logic       s_axil_arready,
  input wire logic [1:0] s_axil_rresp,
  input wire logic       s_axil_rvalid,
  input wire logic       pulse_output_zero,
  input wire logic       pulse_output_one
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  out_reset_a: assert property (!aresetn |=> !pulse_output_zero && !pulse_output_one)
    else $error("output high during reset");
  rdy_reset_a: assert property (!aresetn |=> s_axil_awready && s_axil_wready && s_axil_arready)
    else $error("bus not ready after reset");
  wr_block_a: assert property (disable iff (!aresetn) s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write taken while response pending");
  rd_block_a: assert property (disable iff (!aresetn) s_axil_rvalid |-> !s_axil_arready)
    else $error("read taken while data pending");
  rd_answer_a: assert property (disable iff (!aresetn) s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read answer missing");
  wr_answer_a: assert property (disable iff (!aresetn)
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##[1:2] s_axil_bvalid)
    else $error("write answer missing");
  bad_addr_a: assert property (disable iff (!aresetn)
    s_axil_arvalid && s_axil_arready && s_axil_araddr > 8'h44 |=> s_axil_rresp == AXI_SLVERR)
    else $error("unmapped read not refused");
  status_ok_a: assert property (disable iff (!aresetn)
    s_axil_arvalid && s_axil_arready && s_axil_araddr == OFS_STATUS |=> s_axil_rresp == AXI_OKAY)
    else $error("status read refused");
  // Main scenarios reached
  cover property ($rose(pulse_output_zero));
  cover property ($rose(pulse_output_one));
  cover property (s_axil_arvalid && s_axil_arready && s_axil_araddr > 8'h44);
endmodule : pulse_gen_top_checker

bind pulse_gen_top pulse_gen_top_checker #(.MS_DIV(MS_DIV)) u_checker (
  .aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid,
  .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rresp, .s_axil_rvalid,
  .pulse_output_zero, .pulse_output_one
);

// ### tb/load_model.sv
// External load on one pulse output: counts edges, times levels.
// Assumes a registered output sampled on the rising clock edge.
`timescale 1ns/1ps
module load_model (
  input  wire logic aclk,
  input  wire logic level,
  output int        rises,
  output int        last_high,
  output int        last_low
);
  int   run;   // Clocks at present level
  logic prev;  // Level at last edge
  initial begin
    rises = 0;
    last_high = 0;
    last_low = 0;
    run = 0;
    prev = 1'b0;
  end
  // Time each level, count rising edges
  always @(posedge aclk) begin
    if (level !== prev) begin
      if (level) begin
        rises <= rises + 1;
        last_low <= run;
      end else begin
        last_high <= run;
      end
      run <= 1;
    end else begin
      run <= run + 1;
    end
    prev <= level;
  end
endmodule : load_model

// ### tb/pulse_gen_top_test.sv
// Self-checking bench for the dual pulse generator.
// Assumes one AXI4-Lite master here, loads on both outputs.
`timescale 1ns/1ps
module pulse_gen_top_test;
  import pulse_gen_pkg::*;
  localparam int unsigned MSD = 4;  // Shortened ms tick
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_arvalid = 1'b0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic pulse_output_zero, pulse_output_one;
  int n_errors = 0, n_compared = 0, cycles = 0;
  int rises0, high0, low0, rises1, high1, low1, r0;
  pulse_gen_top #(.MS_DIV(MSD)) DUT (
    .aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
    .s_axil_wstrb(4'hf), .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
    .s_axil_bready(1'b1), .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
    .s_axil_rresp, .s_axil_rvalid, .s_axil_rready(1'b1), .pulse_output_zero, .pulse_output_one
  );
  load_model load0 (.aclk, .level(pulse_output_zero), .rises(rises0), .last_high(high0), .last_low(low0));
  load_model load1 (.aclk, .level(pulse_output_one), .rises(rises1), .last_high(high1), .last_low(low1));
  always #12.5 aclk = ~aclk;
  // Cut a hang short
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Bus write, both halves offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 1, w = 1;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axil_awready) begin
        aw = 0;
        s_axil_awvalid <= 1'b0;
      end
      if (w && s_axil_wready) begin
        w = 0;
        s_axil_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axil_bvalid);
    check(s_axil_bresp, AXI_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    check(v, exp);
  endtask : rd_chk
  task automatic wait_idle();
    logic [31:0] v;
    logic [1:0] r;
    repeat (500) begin
      rd(OFS_STATUS, v, r);
      if (v[STS_IDLE] === 1'b1) break;
    end
  endtask : wait_idle
  task automatic t_regs();
    logic [31:0] v;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(4 * i), 32'h0);
      rd_chk(8'(32 + 4 * i), 32'h0);
    end
    rd_chk(OFS_STATUS, 32'h80);
    wr(CH_STRIDE + OFS_CYCLE, 32'habcd1234);
    rd_chk(CH_STRIDE + OFS_CYCLE, 32'h1234);
    wr(OFS_COUNT, 32'hffffffff);
    rd_chk(OFS_COUNT, 32'hffffffff);
    rd(8'h80, v, r);
    check(r, AXI_SLVERR);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_train();
    // odd cycle kept legal on long base
    wr(OFS_CYCLE, 32'd3);
    wr(OFS_COUNT, 32'd2);
    wr(OFS_CTRL, 32'h8d);
    r0 = rises0;
    wr(OFS_INVOKE, 32'h0);
    rd_chk(OFS_STATUS, 32'h00);
    wait_idle();
    check(rises0 - r0, 2);
    check(high0, MSD);
    check(low0, 2 * MSD);
    check(pulse_output_zero, 1'b0);
    $display("t_train done");
  endtask : t_train
  // Three invokes: the first starts a train, two more while it runs
  task automatic burst();
    wr(OFS_CYCLE, 32'd0);
    wr(OFS_COUNT, 32'd1);
    wr(OFS_CTRL, 32'h85);
    wr(OFS_INVOKE, 32'h0);
    wr(OFS_CYCLE, 32'd4);
    wr(OFS_INVOKE, 32'h0);
    wr(OFS_INVOKE, 32'h0);
  endtask : burst
  task automatic t_pipe();
    r0 = rises0;
    burst();
    rd_chk(OFS_STATUS, 32'h40);
    wait_idle();
    check(rises0 - r0, 2);
    check(low0, US_CYCLES);
    check(high0, 2 * US_CYCLES);
    rd_chk(OFS_STATUS, 32'hc0);
    wr(OFS_RUN, 32'h1);
    rd_chk(OFS_STATUS, 32'h80);
    burst();
    wait_idle();
    rd_chk(OFS_STATUS, 32'hc0);
    wr(OFS_STATUS, 32'h40);
    rd_chk(OFS_STATUS, 32'h80);
    $display("t_pipe done");
  endtask : t_pipe
  task automatic t_pwm();
    logic [15:0] wd [2] = '{16'd5, 16'd0};
    wr(CH_STRIDE + OFS_CYCLE, 32'd5);
    wr(CH_STRIDE + OFS_WIDTH, 32'd2);
    wr(CH_STRIDE + OFS_CTRL, 32'hcb);
    repeat (40) @(posedge aclk);
    check(rises1, 0);
    wr(OFS_INVOKE, 32'h1);
    repeat (100) @(posedge aclk);
    check(high1, 2 * MSD);
    check(low1, 3 * MSD);
    check(rises0 - r0, 0);
    wr(CH_STRIDE + OFS_WIDTH, 32'd3);
    wr(CH_STRIDE + OFS_CTRL, 32'hca);
    wr(OFS_INVOKE, 32'h1);
    repeat (100) @(posedge aclk);
    check(high1, 3 * MSD);
    check(low1, 2 * MSD);
    for (int i = 0; i < 2; i++) begin
      wr(CH_STRIDE + OFS_WIDTH, {16'h0, wd[i]});
      wr(OFS_INVOKE, 32'h1);
      repeat (20) @(posedge aclk);
      r0 = rises1;
      repeat (60) @(posedge aclk);
      check(rises1 - r0, 0);
      check(pulse_output_one, i == 0);
    end
    $display("t_pwm done");
  endtask : t_pwm
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_train();
    t_pipe();
    r0 = rises0;
    t_pwm();
    final_report();
  end
endmodule : pulse_gen_top_test
